// File: shared/option_bits_defines.vh
// Constants for the program option bit controller.
// Assumes inclusion by bare name from the design file.
`ifndef OPTION_BITS_DEFINES_VH
`define OPTION_BITS_DEFINES_VH
// Option cell bit positions (a set bit means programmed)
`define OPT_LOW_NOISE_BIT   0
`define OPT_READ_PROT_BIT   1
`define OPT_LATCH_DIS_BIT   2
`define OPT_WDOG_EN_BIT     3
`define OPT_TEST_DIS_BIT    4
`define OPT_WIDTH           5
// Register byte offsets
`define REG_OPTIONS_OFS     12'h000
`define REG_STATUS_OFS      12'h004
`define REG_CONTROL_OFS     12'h008
// Field positions in the status register
`define STAT_PROG_MODE_BIT  0
`define STAT_TEST_MODE_BIT  1
`define STAT_READ_REF_BIT   2
`define STAT_PROG_REF_BIT   3
`define STAT_WDOG_RUN_BIT   4
`define STAT_CLK_DIV1_BIT   5
// Field positions in the control register
`define CTRL_WDOG_REQ_BIT   0
`define CTRL_TEST_REQ_BIT   1
// Reset values
`define OPTIONS_RST         32'h00000000
`define CONTROL_RST         32'h00000000
// Load cycles after reset release before options count as valid
`define LOAD_CYCLES         4'h3
`endif

// File: hdl/program_option_bit_control.v
// Option bit controller: latches one-time option cells, decodes them,
// and steers clocking, read protection, latches, watchdog and mode entry.
// Assumes option cells and programming-mode pins arrive from outside the
// hclk domain; registers are reached over AHB-Lite (single word access).
//
// How it works
// R1: Low-noise comes only from its option cell, never from a written register.
// R2: Low-noise programmed bypasses the divide-by-two, so core and timer clocks run at osc_in.
// R3: With low-noise the programmer-side clock must stay at or below 4 MHz (250 ns cycle); the controller does not check it and samples the pins every hclk.
// R4: In programming mode osc_in is chip enable and four port bits take programmer roles.
// R5: Read protection refuses every external read of program memory.
// R6: Under read protection internal program-memory loads still run; external loads do not exist.
// R7: Read protection and low-noise decode independently.
// R8: Latch-disable turns off every input auto-latch at once.
// R9: Watchdog-enable runs the watchdog from reset release, through halt and stop, unstoppable.
// R10: Test-mode-disable blocks programming and factory test mode, refusing all programmer access.
// R11: A new test-mode-disable value takes full effect only after the next power-up.
// R12: With latch-disable clear the auto-latches are active by default.
// R13: Options are captured into read-only latches at reset and stay fixed while running.
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "option_bits_defines.vh"
module program_option_bit_control #(
  parameter OPTW = `OPT_WIDTH
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        por_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Option cells and programming pins
  input  wire [4:0]  option_cells,
  input  wire        osc_in,
  input  wire        port3_bit1,
  input  wire        port3_bit2,
  input  wire        port3_bit3,
  input  wire        port0_bit2,
  input  wire        factory_test_req,
  input  wire        ext_read_req,
  input  wire        ext_prog_req,
  input  wire        load_program_mem,
  input  wire        load_program_mem_autoinc,
  // Decoded controls
  output reg         clk_div2_bypass,
  output reg         auto_latch_en,
  output reg         watchdog_run,
  output reg         watchdog_stoppable,
  output reg         prog_mode,
  output reg         factory_test_mode,
  output reg         ext_read_grant,
  output reg         ext_read_refused,
  output reg         ext_prog_grant,
  output reg         int_load_grant
);

  // Two-flop synchronisers for all pin-side inputs
  localparam NSYNC = OPTW + 8;
  wire [NSYNC-1:0] sync_in;
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  assign sync_in = {option_cells, osc_in, port3_bit1, port3_bit2, port3_bit3,
                    port0_bit2, factory_test_req, ext_read_req, ext_prog_req};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end
  wire [OPTW-1:0] cells_s  = sync2_q[NSYNC-1:8];
  wire chip_en_n_s         = sync2_q[7];        // osc_in acts as chip enable
  wire out_en_n_s          = sync2_q[6];        // port3_bit1
  wire prog_mode_select    = sync2_q[5];        // port3_bit2
  wire prog_volt_s         = sync2_q[4];        // port3_bit3
  wire program_strobe_n    = sync2_q[3];        // port0_bit2
  wire ftest_s             = sync2_q[2];
  wire rd_req_s            = sync2_q[1];
  wire pg_req_s            = sync2_q[0];

  // Option capture window: cells are sampled for a few cycles after reset
  reg [3:0]      load_cnt_q;
  reg [OPTW-1:0] opt_q;
  reg            test_dis_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_cnt_q <= 4'h0;
      opt_q      <= {OPTW{1'b0}};
    end else if (load_cnt_q != `LOAD_CYCLES) begin
      load_cnt_q <= load_cnt_q + 4'h1;
      opt_q      <= cells_s;                                  // [R13]
    end
  end
  wire opt_valid = (load_cnt_q == `LOAD_CYCLES);

  // Test-disable latched only on power-up, so a fresh value needs a power cycle
  reg por_seen_q;
  always @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      por_seen_q <= 1'b0;
      test_dis_q <= 1'b0;
    end else if (!por_seen_q && hresetn && opt_valid) begin
      por_seen_q <= 1'b1;
      test_dis_q <= opt_q[`OPT_TEST_DIS_BIT];                 // [R11]
    end
  end

  // Independent decodes; each bit drives only its own control
  wire low_noise  = opt_q[`OPT_LOW_NOISE_BIT];               // [R1] [R7]
  wire read_prot  = opt_q[`OPT_READ_PROT_BIT];               // [R7]
  wire latch_dis  = opt_q[`OPT_LATCH_DIS_BIT];
  wire wdog_perm  = opt_q[`OPT_WDOG_EN_BIT];
  wire lockout    = test_dis_q | !por_seen_q;                // Closed until settled

  // Software watchdog and test request bits
  reg [1:0] ctrl_q;

  // Programming mode: chip enable low and mode select high, unless locked out
  wire pm_pins   = !chip_en_n_s && prog_mode_select;         // [R4]
  wire pm_active = pm_pins && !lockout && opt_valid;         // [R10]
  wire ft_active = (ftest_s | ctrl_q[`CTRL_TEST_REQ_BIT]) && !lockout && opt_valid; // [R10]

  // Decoded outputs, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_div2_bypass    <= 1'b0;
      auto_latch_en      <= 1'b1;
      watchdog_run       <= 1'b0;
      watchdog_stoppable <= 1'b1;
      prog_mode          <= 1'b0;
      factory_test_mode  <= 1'b0;
      ext_read_grant     <= 1'b0;
      ext_read_refused   <= 1'b0;
      ext_prog_grant     <= 1'b0;
      int_load_grant     <= 1'b0;
    end else begin
      clk_div2_bypass    <= opt_valid && low_noise;                        // [R2]
      auto_latch_en      <= !(opt_valid && latch_dis);                     // [R8] [R12]
      // Permanent watchdog ignores halt/stop and the software bit
      watchdog_run       <= opt_valid && (wdog_perm || ctrl_q[`CTRL_WDOG_REQ_BIT]); // [R9]
      watchdog_stoppable <= !(opt_valid && wdog_perm);                     // [R9]
      prog_mode          <= pm_active;                                     // [R10]
      factory_test_mode  <= ft_active;
      // Read: output enable low, strobe high, in programming mode
      ext_read_grant     <= pm_active && rd_req_s && !out_en_n_s && program_strobe_n
                            && !read_prot;                                 // [R5]
      ext_read_refused   <= rd_req_s && (read_prot || !pm_active);         // [R5] [R10]
      // Program: strobe low with programming voltage present
      ext_prog_grant     <= pm_active && pg_req_s && !program_strobe_n && prog_volt_s; // [R4]
      // Internal loads are unaffected by protection
      int_load_grant     <= opt_valid && (load_program_mem || load_program_mem_autoinc); // [R6]
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  reg        wr_pend_q;
  reg [11:0] wr_addr_q;
  wire       acc = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= acc && hwrite;
      if (acc)
        wr_addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Writes land in control only; options register is read-only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl_q <= 2'b00;
    else if (wr_pend_q && wr_addr_q == `REG_CONTROL_OFS)
      ctrl_q <= hwdata[1:0];                                  // [R1] [R13]
  end

  // Read data registered at address phase; unmapped reads as zero
  wire [31:0] status_w = {26'h0000000, clk_div2_bypass, watchdog_run,
                          ext_prog_grant, ext_read_refused, factory_test_mode, prog_mode};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite) begin
      case (haddr)
        `REG_OPTIONS_OFS: hrdata <= {26'h0000000, opt_valid, opt_q};
        `REG_STATUS_OFS:  hrdata <= status_w;
        `REG_CONTROL_OFS: hrdata <= {30'h00000000, ctrl_q};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// File: bench/option_programmer.sv
// Programmer model: drives the programming-mode pins from a command.
// Assumes cmd changes just after a rising hclk edge.
`timescale 1ns/10ps
module option_programmer (
  input  wire logic       hclk,
  input  wire logic [1:0] cmd,
  output logic            osc_in = 1'b1,
  output logic            port3_bit1 = 1'b1,
  output logic            port3_bit2 = 1'b0,
  output logic            port3_bit3 = 1'b0,
  output logic            port0_bit2 = 1'b1,
  output logic            ext_read_req = 1'b0,
  output logic            ext_prog_req = 1'b0
);
  // 1 reads, 2 programs; idle deselects chip
  // Pins move once per hclk at most; nothing holds them to the 250 ns slow-clock limit
  always @(posedge hclk) begin
    osc_in       <= (cmd == 2'h0);
    port3_bit2   <= (cmd != 2'h0);
    port3_bit1   <= (cmd != 2'h1);
    port3_bit3   <= (cmd == 2'h2);
    port0_bit2   <= (cmd != 2'h2);
    ext_read_req <= (cmd == 2'h1);
    ext_prog_req <= (cmd == 2'h2);
  end
endmodule

// File: bench/option_bits_sva.sv
// Checker: option decode and pin relations at the controller ports.
// Assumes one clock domain, bound onto the controller.
`timescale 1ns/10ps
module option_bits_sva (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire osc_in,
  input wire port3_bit2,
  input wire load_program_mem,
  input wire load_program_mem_autoinc,
  input wire clk_div2_bypass,
  input wire auto_latch_en,
  input wire watchdog_run,
  input wire watchdog_stoppable,
  input wire prog_mode,
  input wire ext_read_grant,
  input wire ext_read_refused,
  input wire ext_prog_grant,
  input wire int_load_grant
);
  logic [3:0] up_q;
  // Cycles since release; decode settles by edge 4
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fixed; up_q > 4'h6 |-> $stable({clk_div2_bypass, auto_latch_en}); endproperty
  property p_wdog; !watchdog_stoppable |-> watchdog_run; endproperty
  property p_refuse; ext_read_refused |-> !ext_read_grant; endproperty
  property p_rdmode; ext_read_grant |-> prog_mode; endproperty
  property p_pgmode; ext_prog_grant |-> prog_mode; endproperty
  property p_pins; prog_mode |-> $past(!osc_in && port3_bit2, 3); endproperty
  property p_load; up_q > 4'h6 && load_program_mem |-> ##[1:3] int_load_grant; endproperty
  property p_bus; hreadyout && !hresp; endproperty
  a_fixed: assert property (p_fixed) else $error("decode moved");
  a_wdog: assert property (p_wdog) else $error("watchdog idle");
  a_refuse: assert property (p_refuse) else $error("refused read granted");
  a_rdmode: assert property (p_rdmode) else $error("read outside mode");
  a_pgmode: assert property (p_pgmode) else $error("program outside mode");
  a_pins: assert property (p_pins) else $error("mode without pins");
  a_load: assert property (p_load) else $error("load not granted");
  a_bus: assert property (p_bus) else $error("bus not ready");
  c_ref: cover property (prog_mode && ext_read_refused);
  c_prog: cover property (ext_prog_grant);
  c_wdog: cover property (!watchdog_stoppable);
endmodule
bind program_option_bit_control option_bits_sva i_option_bits_sva (.*);

// File: bench/program_option_bit_control_tb_top.sv
// Bench: boots the controller under every option set, checks decode.
// Assumes the programmer model and checker compile first.
`timescale 1ns/10ps
module program_option_bit_control_tb_top;
  logic        hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, ld = 0, lda = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0, cmd = 0;
  logic [31:0] hwdata = 0, rd, rnd;
  logic [4:0]  v = 0;
  wire  [31:0] hrdata;
  wire  [9:0]  o;
  wire  [6:0]  p;
  wire         hreadyout, hresp;
  integer      mismatches = 0, comparisons = 0, seed = 35721, cyc = 0, i;
  always #5 hclk = ~hclk;
  option_programmer i_option_programmer (.hclk(hclk), .cmd(cmd), .osc_in(p[0]),
    .port3_bit1(p[1]), .port3_bit2(p[2]), .port3_bit3(p[3]), .port0_bit2(p[4]),
    .ext_read_req(p[5]), .ext_prog_req(p[6]));
  program_option_bit_control i_program_option_bit_control (.hclk(hclk),
    .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .option_cells(v),
    .osc_in(p[0]), .port3_bit1(p[1]), .port3_bit2(p[2]), .port3_bit3(p[3]),
    .port0_bit2(p[4]), .factory_test_req(1'b0), .ext_read_req(p[5]),
    .ext_prog_req(p[6]), .load_program_mem(ld), .load_program_mem_autoinc(lda),
    .clk_div2_bypass(o[0]), .auto_latch_en(o[1]), .watchdog_run(o[2]),
    .watchdog_stoppable(o[3]), .prog_mode(o[4]), .factory_test_mode(o[5]),
    .ext_read_grant(o[6]), .ext_read_refused(o[7]), .ext_prog_grant(o[8]),
    .int_load_grant(o[9]));
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Single AHB word transfer, entered just after a rising edge
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Reset with new cells; pw also cycles power
  task boot(input logic [4:0] c, input logic pw);
    hresetn <= 0;
    por_n <= ~pw;
    v <= c;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    por_n <= 1;
    repeat (6) @(posedge hclk);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    for (i = 0; i < 32; i++) begin
      boot(i[4:0], 1);
      rnd = $random(seed);
      chk("bypass", o[0], v[0]);
      chk("latch", o[1], !v[2]);
      chk("stoppable", o[3], !v[3]);
      ahb(0, 12'h000, 0);
      chk("options", rd, {26'h0, 1'b1, v});
      ahb(1, 12'h000, rnd);
      ahb(0, 12'h000, 0);
      chk("options ro", rd, {26'h0, 1'b1, v});
      ahb(1, 12'h008, 32'h1);
      ahb(0, 12'h008, 0);
      chk("ctrl", rd, 32'h1);
      chk("wdog sw", o[2], 1'b1);
      ahb(1, 12'h008, 32'h2);
      repeat (3) @(posedge hclk);
      chk("ftest", o[5], !v[4]);
      ahb(1, 12'h008, 32'h0);
      repeat (4) @(posedge hclk);
      chk("wdog", o[2], v[3]);
      ahb(0, 12'h00c, 0);
      chk("unmapped", rd, 32'h0);
      cmd <= 1;
      ld <= rnd[8];
      lda <= rnd[9];
      repeat (6) @(posedge hclk);
      chk("mode", o[4], !v[4]);
      chk("rd grant", o[6], !v[4] && !v[1]);
      chk("refused", o[7], v[1] | v[4]);
      chk("load", o[9], rnd[8] | rnd[9]);
      ahb(0, 12'h004, 0);
      chk("status", rd, {26'h0, v[0], v[3], 1'b0, v[1] | v[4], 1'b0, !v[4]});
      cmd <= 2;
      v <= ~v;
      repeat (6) @(posedge hclk);
      chk("pgm grant", o[8], !i[4]);
      chk("held", o[0], i[0]);
      cmd <= 0;
      $display("test options %h done", i[4:0]);
    end
    boot(5'h00, 1);
    boot(5'h10, 0);
    cmd <= 1;
    repeat (6) @(posedge hclk);
    chk("soft lock", o[4], 1'b1);
    cmd <= 0;
    boot(5'h10, 1);
    cmd <= 1;
    repeat (6) @(posedge hclk);
    chk("power lock", o[4], 1'b0);
    $display("test lockout done");
    conclude();
  end
endmodule
